//--- hw/rsmc_filter.sv
// three-stage synchroniser and stability filter with edge pulses
module rsmc_filter #(
  parameter int unsigned STABLE_CYCLES = 600,
  parameter logic        INIT_LEVEL    = 1'h0
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic PIN,
  output logic      LEVEL,
  output logic      RISE,
  output logic      FALL
);

  rsmc_pkg::rsmc_filt_t q;
  rsmc_pkg::rsmc_filt_t d;

  // ****************************************************************
  // filter
  // ****************************************************************
  always_comb begin
    d      = q;
    d.sync = {q.sync[1:0], PIN};
    d.rise = 1'h0;
    d.fall = 1'h0;
    // counts only while stages two and three agree on a new level
    if (q.sync[2] != q.sync[1] || q.sync[2] == q.level) begin
      d.cnt = 32'h0;
    end else if (q.cnt == 32'(STABLE_CYCLES - 1)) begin
      d.cnt   = 32'h0;
      d.level = q.sync[2];
      d.rise  = q.sync[2];
      d.fall  = ~q.sync[2];
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '{sync: {3{INIT_LEVEL}}, cnt: 32'h0, level: INIT_LEVEL, rise: 1'h0, fall: 1'h0};
    end else begin
      q <= d;
    end
  end

  assign LEVEL = q.level;
  assign RISE  = q.rise;
  assign FALL  = q.fall;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_filter_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    $changed(q.level) |-> $past(q.cnt) == 32'(STABLE_CYCLES - 1))
    else $error("filtered level changed before the stable time");

endmodule // rsmc_filter

//--- hw/rsmc_pkg.sv
// constants and types shared by the reset and sleep-mode controller
package rsmc_pkg;

  // ****************************************************************
  // clock
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ****************************************************************
  // times as printed, and derived cycle counts (least times round up)
  // ****************************************************************
  localparam int unsigned REL_4MS_US      = 4000;
  localparam int unsigned REL_8MS_US      = 8000;
  localparam int unsigned REL_15MS_US     = 15000;
  localparam int unsigned REL_30MS_US     = 30000;
  localparam int unsigned REL_4MS_CYC     = (REL_4MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REL_8MS_CYC     = (REL_8MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REL_15MS_CYC    = (REL_15MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REL_30MS_CYC    = (REL_30MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset_assert_delay: no figure given, plain default
  localparam int unsigned RST_ASSERT_DLY_US  = 10;
  localparam int unsigned RST_ASSERT_DLY_CYC =
    (RST_ASSERT_DLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned MODE_FILTER_NS  = 6000;
  localparam int unsigned MODE_FILTER_CYC = (MODE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned WAKE_PULSE_US   = 70;
  localparam int unsigned WAKE_PULSE_CYC  =
    (WAKE_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic MODE_LEVEL_RST = 1'h0;
  localparam logic BUS_LEVEL_RST  = 1'h1;
  localparam logic ARMED_RST      = 1'h1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_WAIT_VCC   = 3'h0,
    ST_REL_DLY    = 3'h1,
    ST_RUN        = 3'h2,
    ST_ASSERT_DLY = 3'h3,
    ST_SLEEP      = 3'h4
  } rsmc_state_t;

  typedef struct packed {
    logic [2:0]  vsync;
    logic        vcc;
    rsmc_state_t st;
    logic [31:0] cnt;
    logic        armed;
    logic        rst_n;
    logic        reg_on;
    logic        sleep;
  } rsmc_ctl_t;

  typedef struct packed {
    logic [2:0]  sync;
    logic [31:0] cnt;
    logic        level;
    logic        rise;
    logic        fall;
  } rsmc_filt_t;

endpackage

//--- hw/rsmc_top.sv
// reset generation and sleep/normal mode control
module rsmc_top #(
  parameter int unsigned RELEASE_CYCLES = rsmc_pkg::REL_8MS_CYC,
  parameter int unsigned WAKE_CYCLES    = rsmc_pkg::WAKE_PULSE_CYC
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic VCC_OK,
  input  wire logic MODE_PIN,
  input  wire logic MODE_PIN_FLOAT,
  input  wire logic BUS_RX,
  output logic      RESET_N,
  output logic      REG_ON,
  output logic      SLEEP
);

  rsmc_pkg::rsmc_ctl_t q;
  rsmc_pkg::rsmc_ctl_t d;

  logic mode_pin_eff;
  logic mode_level;
  logic mode_rise;
  logic mode_fall;
  logic bus_rise;
  logic bus_fall;
  logic bus_chg;

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  // undriven pin is pulled down
  assign mode_pin_eff = MODE_PIN & ~MODE_PIN_FLOAT;

  rsmc_filter #(
    .STABLE_CYCLES (rsmc_pkg::MODE_FILTER_CYC),
    .INIT_LEVEL    (rsmc_pkg::MODE_LEVEL_RST)
  ) u_mode_filt (
    .CLK   (CLK),
    .RST_N (RST_N),
    .PIN   (mode_pin_eff),
    .LEVEL (mode_level),
    .RISE  (mode_rise),
    .FALL  (mode_fall)
  );

  // a settled change of either polarity is a qualifying wake pulse
  rsmc_filter #(
    .STABLE_CYCLES (WAKE_CYCLES),
    .INIT_LEVEL    (rsmc_pkg::BUS_LEVEL_RST)
  ) u_bus_filt (
    .CLK   (CLK),
    .RST_N (RST_N),
    .PIN   (BUS_RX),
    .LEVEL (),
    .RISE  (bus_rise),
    .FALL  (bus_fall)
  );

  assign bus_chg = bus_rise | bus_fall;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    d       = q;
    d.vsync = {q.vsync[1:0], VCC_OK};
    if (q.vsync[2] == q.vsync[1]) begin
      d.vcc = q.vsync[2];
    end
    case (q.st)
      rsmc_pkg::ST_WAIT_VCC: begin
        d.cnt   = 32'h0;
        d.rst_n = 1'h0;
        if (q.vcc) begin
          d.st = rsmc_pkg::ST_REL_DLY;
        end
      end
      rsmc_pkg::ST_REL_DLY: begin
        if (!q.vcc) begin
          d.st  = rsmc_pkg::ST_WAIT_VCC;
          d.cnt = 32'h0;
        end else if (q.cnt == 32'(RELEASE_CYCLES - 1)) begin
          d.st    = rsmc_pkg::ST_RUN;
          d.cnt   = 32'h0;
          d.rst_n = 1'h1;
        end else begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      rsmc_pkg::ST_RUN: begin
        if (!q.vcc) begin
          d.st  = rsmc_pkg::ST_ASSERT_DLY;
          d.cnt = 32'h0;
        end
      end
      rsmc_pkg::ST_ASSERT_DLY: begin
        // a dropout shorter than the assert delay leaves reset high
        if (q.vcc) begin
          d.st  = rsmc_pkg::ST_RUN;
          d.cnt = 32'h0;
        end else if (q.cnt == 32'(rsmc_pkg::RST_ASSERT_DLY_CYC - 1)) begin
          d.st    = rsmc_pkg::ST_WAIT_VCC;
          d.cnt   = 32'h0;
          d.rst_n = 1'h0;
        end else begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      rsmc_pkg::ST_SLEEP: begin
        // mode pin edges cannot wake; only the bus can
        if (bus_chg) begin
          d.st     = rsmc_pkg::ST_WAIT_VCC;
          d.reg_on = 1'h1;
          d.sleep  = 1'h0;
          d.armed  = 1'h0;
        end
      end
      default: begin
        d.st = rsmc_pkg::ST_WAIT_VCC;
      end
    endcase
    // a rise in the wake cycle itself still arms: the set wins over the clear
    if (mode_rise) begin
      d.armed = 1'h1;
    end
    // falling edge wins over every running state, transmitting or not
    if (q.st != rsmc_pkg::ST_SLEEP && mode_fall && q.armed) begin
      d.st     = rsmc_pkg::ST_SLEEP;
      d.cnt    = 32'h0;
      d.reg_on = 1'h0;
      d.rst_n  = 1'h0;
      d.sleep  = 1'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '{vsync: 3'h0, vcc: 1'h0, st: rsmc_pkg::ST_WAIT_VCC, cnt: 32'h0,
             armed: rsmc_pkg::ARMED_RST, rst_n: 1'h0, reg_on: 1'h1, sleep: 1'h0};
    end else begin
      q <= d;
    end
  end

  assign RESET_N = q.rst_n;
  assign REG_ON  = q.reg_on;
  assign SLEEP   = q.sleep;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_release_after_delay: assert property (
    $rose(RESET_N) |-> $past(q.st) == rsmc_pkg::ST_REL_DLY
                       && $past(q.cnt) == 32'(RELEASE_CYCLES - 1))
    else $error("reset released without full delay");

  chk_vcc_low_reset: assert property (
    q.st == rsmc_pkg::ST_WAIT_VCC |-> !RESET_N)
    else $error("reset high while waiting for supply");

  chk_assert_delay: assert property (
    $fell(RESET_N) && !SLEEP |-> $past(q.st) == rsmc_pkg::ST_ASSERT_DLY
                                && $past(q.cnt) == 32'(rsmc_pkg::RST_ASSERT_DLY_CYC - 1))
    else $error("reset fell before assert delay");

  chk_fall_sleep: assert property (
    !SLEEP && mode_fall && q.armed |=> SLEEP && !REG_ON && !RESET_N)
    else $error("falling edge did not enter sleep");

  chk_high_normal: assert property (
    !SLEEP && mode_level |=> !SLEEP)
    else $error("left normal mode while mode pin high");

  chk_pin_no_wake: assert property (
    SLEEP && !bus_chg |=> SLEEP && !REG_ON)
    else $error("left sleep without bus activity");

  chk_bus_wake: assert property (
    SLEEP && bus_chg |=> !SLEEP && REG_ON && !RESET_N
                          && q.st == rsmc_pkg::ST_WAIT_VCC)
    else $error("bus pulse did not wake regulator");

  chk_unarmed_fall: assert property (
    !SLEEP && mode_fall && !q.armed |=> !SLEEP)
    else $error("sleep entered without high then low after wake");

  chk_sleep_reset_low: assert property (
    SLEEP |-> !RESET_N && !REG_ON)
    else $error("reset or regulator active in sleep");

  cov_release:     cover property ($rose(RESET_N));
  cov_dropout:     cover property (q.st == rsmc_pkg::ST_ASSERT_DLY ##1 q.st == rsmc_pkg::ST_RUN);
  cov_sleep_wake:  cover property (SLEEP ##1 !SLEEP);
  cov_unarmed:     cover property (!SLEEP && mode_fall && !q.armed);

endmodule // rsmc_top

//--- tb/rsmc_host_model.sv
// host controller model: drives the mode-control pin and watches the reset output
module rsmc_host_model (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      mode_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // mode pin driver
  // ****************************************************************
  // releases of reset seen by the host; each one is a fresh boot
  int unsigned boots;

  // a push-pull output, so the pin always has a defined level
  initial begin
    mode_pin = 1'h0;
    boots    = 32'h0;
  end

  always @(posedge reset_n) begin
    boots <= boots + 32'h1;
  end

  // changes only just after a rising edge and holds until the next call;
  // a pin tied high for good is just one call with level 1
  // after a bus wake, sleep is asked for only by high then low
  // low slew mode is not modelled, so nothing needs reselecting
  task automatic set_level(input logic lvl);
    @(posedge clk);
    mode_pin <= lvl;
  endtask

endmodule // rsmc_host_model

//--- tb/tb_top.sv
// self-checking testbench of the reset and sleep-mode controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic clk;
  logic rst_n;
  logic vcc_ok;
  logic mode_pin;
  logic mode_float;
  logic bus_rx;
  logic reset_n;
  logic reg_on;
  logic sleep;
  int   bad_count;
  int   n_compared;

  // short counts keep the run brief
  rsmc_top #(.RELEASE_CYCLES(50), .WAKE_CYCLES(20)) rsmc_top_inst (
    .CLK(clk), .RST_N(rst_n), .VCC_OK(vcc_ok), .MODE_PIN(mode_pin),
    .MODE_PIN_FLOAT(mode_float), .BUS_RX(bus_rx),
    .RESET_N(reset_n), .REG_ON(reg_on), .SLEEP(sleep)
  );

  rsmc_host_model rsmc_host_model_inst (
    .clk(clk), .reset_n(reset_n), .mode_pin(mode_pin)
  );

  initial begin
    clk = 1'h0;
  end

  always #5 clk = ~clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic got, input logic exp);
    #1;
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
    #1;
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic power_up;
    @(posedge clk) vcc_ok <= 1'h1;
    tick(40);
    chk(reset_n, 1'h0);
    tick(30);
    chk(reset_n, 1'h1);
  endtask

  task automatic supply_drop;
    @(posedge clk) vcc_ok <= 1'h0;
    tick(100);
    vcc_ok <= 1'h1;
    tick(10);
    chk(reset_n, 1'h1);
    @(posedge clk) vcc_ok <= 1'h0;
    tick(900);
    chk(reset_n, 1'h1);
    tick(200);
    chk(reset_n, 1'h0);
    @(posedge clk) vcc_ok <= 1'h1;
    tick(40);
    chk(reset_n, 1'h0);
    tick(30);
    chk(reset_n, 1'h1);
  endtask

  task automatic mode_sleep;
    rsmc_host_model_inst.set_level(1'h1);
    tick(700);
    chk(sleep, 1'h0);
    // a low glitch shorter than the filter must not sleep
    rsmc_host_model_inst.set_level(1'h0);
    tick(300);
    rsmc_host_model_inst.set_level(1'h1);
    tick(700);
    chk(sleep, 1'h0);
    rsmc_host_model_inst.set_level(1'h0);
    tick(700);
    chk(sleep, 1'h1);
    chk(reg_on, 1'h0);
    chk(reset_n, 1'h0);
    @(posedge clk) vcc_ok <= 1'h0;
    rsmc_host_model_inst.set_level(1'h1);
    tick(700);
    chk(sleep, 1'h1);
    rsmc_host_model_inst.set_level(1'h0);
    tick(700);
    chk(sleep, 1'h1);
  endtask

  task automatic bus_wake;
    // pin raised while asleep: the wake must forget that rise
    rsmc_host_model_inst.set_level(1'h1);
    tick(700);
    chk(sleep, 1'h1);
    @(posedge clk) bus_rx <= 1'h0;
    tick(10);
    bus_rx <= 1'h1;
    tick(50);
    chk(sleep, 1'h1);
    @(posedge clk) bus_rx <= 1'h0;
    tick(40);
    chk(sleep, 1'h0);
    chk(reg_on, 1'h1);
    @(posedge clk) vcc_ok <= 1'h1;
    tick(40);
    chk(reset_n, 1'h0);
    tick(30);
    chk(reset_n, 1'h1);
    rsmc_host_model_inst.set_level(1'h1);
    tick(700);
    chk(sleep, 1'h0);
    // a fall with no rise since the wake is refused
    rsmc_host_model_inst.set_level(1'h0);
    tick(700);
    chk(sleep, 1'h0);
    rsmc_host_model_inst.set_level(1'h1);
    tick(700);
    rsmc_host_model_inst.set_level(1'h0);
    tick(700);
    chk(sleep, 1'h1);
    @(posedge clk) vcc_ok <= 1'h0;
  endtask

  task automatic float_pin;
    // bus idles low here, so this wake is a high pulse
    @(posedge clk) bus_rx <= 1'h1;
    tick(40);
    bus_rx <= 1'h0;
    chk(sleep, 1'h0);
    @(posedge clk) vcc_ok <= 1'h1;
    tick(70);
    chk(reset_n, 1'h1);
    rsmc_host_model_inst.set_level(1'h1);
    tick(700);
    chk(sleep, 1'h0);
    @(posedge clk) mode_float <= 1'h1;
    tick(700);
    chk(sleep, 1'h1);
  endtask

  task automatic mid_reset;
    // reset taken while asleep; supply is still valid
    @(posedge clk) rst_n <= 1'h0;
    tick(3);
    chk(sleep, 1'h0);
    chk(reg_on, 1'h1);
    chk(reset_n, 1'h0);
    @(posedge clk) rst_n <= 1'h1;
    tick(40);
    chk(reset_n, 1'h0);
    tick(30);
    chk(reset_n, 1'h1);
    chk_count(rsmc_host_model_inst.boots, 32'h5);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    bad_count = 0;
    n_compared = 0;
    rst_n = 1'h0;
    vcc_ok = 1'h0;
    mode_float = 1'h0;
    bus_rx = 1'h1;
    tick(5);
    rst_n <= 1'h1;
    tick(1);
    power_up();
    supply_drop();
    mode_sleep();
    bus_wake();
    float_pin();
    mid_reset();
    results();
  end

  // the sequence needs about 10400 cycles; well past that means a hang
  initial begin
    #300000;
    bad_count++;
    results();
  end

endmodule // tb_top
